// >>> core/cwd_top.sv
// configuration word store, decoder and reset/sleep sequencer behind an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "cwd_map.svh"

module cwd_top
    import cwd_pkg::*;
#(
    parameter int PWRUP_CYCLES = `CWD_PWRUP_MS * `CWD_CLK_KHZ
) (
    input wire logic pclk, // bus clock, 100 MHz
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high writes
    input wire logic [17:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic ext_reset_n, // external reset pin, active low
    input wire logic vdd_above_hi, // supply above 4.0V comparator
    input wire logic vdd_above_lo, // supply above 2.5V comparator
    input wire logic watchdog_timeout, // watchdog counter expired
    input wire logic irq_pending, // an enabled interrupt is pending
    input wire logic prog_mode, // programming mode pin
    input wire logic oscillator_input_pin, // crystal or external clock input
    output cwd_settings_t settings, // held decoded settings
    output logic chip_reset_hold, // chip kept in reset
    output logic sleeping, // chip in sleep
    output logic xtal_drive_en, // crystal amplifier enable
    output logic program_memory_erase // one-cycle bulk erase of program memory
);
    localparam logic [`CWD_CNT_W-1:0] PWRUP_LAST = `CWD_CNT_W'(PWRUP_CYCLES - 1);
    localparam logic [`CWD_CNT_W-1:0] OST_LAST = `CWD_CNT_W'(`CWD_OST_CYCLES - 1);

    // word as software would read it: unused positions forced to 1
    function automatic logic [15:0] cfg_view(input logic [15:0] w);
        cfg_view = w | `CWD_UNUSED_MASK;
    endfunction

    function automatic cwd_settings_t decode(input logic [15:0] w);
        cwd_settings_t s;
        s.code_protect_on = ~w[`CWD_PROTECT_BIT];
        s.brownout_threshold_select = w[`CWD_BROWN_SEL_BIT];
        s.brownout_reset_fuse = w[`CWD_BROWN_EN_BIT];
        s.powerup_delay_enable_n = w[`CWD_PWRUP_N_BIT];
        s.watchdog_enable_fuse = w[`CWD_WATCHDOG_BIT];
        s.osc_mode = cwd_osc_mode_t'({w[`CWD_OSC_HI_BIT], w[`CWD_OSC_LO_BIT]});
        return s;
    endfunction

    function automatic logic is_crystal(input cwd_osc_mode_t m);
        is_crystal = (m != CWD_OSC_RC);
    endfunction

    logic [`CWD_SYNC_W-1:0] pins_s;
    logic ext_reset_s_n;
    logic hi_s;
    logic lo_s;
    logic wd_s;
    logic irq_s;
    logic prog_s;
    logic osc_s;
    logic osc_prev;
    logic osc_rise;

    cwd_sync #(
        .WIDTH(`CWD_SYNC_W)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in({ext_reset_n, vdd_above_hi, vdd_above_lo, watchdog_timeout,
                   irq_pending, prog_mode, oscillator_input_pin}),
        .sync_out(pins_s)
    );

    assign {ext_reset_s_n, hi_s, lo_s, wd_s, irq_s, prog_s, osc_s} = pins_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_prev <= 1'b0;
        end else begin
            osc_prev <= osc_s;
        end
    end

    // external clock and crystal look the same here: only input edges are counted
    assign osc_rise = osc_s & ~osc_prev;

    // ---------------- configuration store ----------------
    logic [15:0] cfg_word;
    logic [15:0] idx;
    logic in_cfg_space;
    logic setup;
    logic wr_done;
    logic wr_cfg;
    logic wr_ctrl;
    logic sleep_req;
    logic erase_req;

    assign idx = paddr[17:2];
    assign in_cfg_space = (idx >= `CWD_CFG_SPACE_LO) && (idx <= `CWD_CFG_SPACE_HI);
    assign setup = psel & ~penable;
    assign wr_done = psel & penable & pready & pwrite & ~pslverr;
    assign wr_cfg = wr_done & (idx == `CWD_CFG_INDEX);
    assign wr_ctrl = wr_done & (idx == `CWD_CONTROL_INDEX);
    assign sleep_req = wr_ctrl & pwdata[`CWD_CTRL_SLEEP_BIT];
    // erase is refused outside programming mode, like every configuration access
    assign erase_req = wr_ctrl & pwdata[`CWD_CTRL_ERASE_BIT] & prog_s;

    // one-time cells: a write can only program bits to 0; only bulk erase or presetn restores 1s,
    // and erase takes the program memory with it, so protection lifts only on erase or presetn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_word <= `CWD_ERASED;
        end else if (erase_req) begin
            cfg_word <= `CWD_ERASED;
        end else if (wr_cfg) begin
            cfg_word <= cfg_word & cfg_view(pwdata[15:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_memory_erase <= 1'b0;
        end else begin
            program_memory_erase <= erase_req;
        end
    end

    // ---------------- sequencer ----------------
    cwd_state_t state;
    cwd_state_t next_state;
    logic power_class;
    logic [`CWD_CNT_W-1:0] cnt;
    logic vdd_ok;
    logic brown_trip;
    logic wd_reset;
    logic wake;
    logic xtal;

    assign vdd_ok = settings.brownout_threshold_select ? hi_s : lo_s;
    assign brown_trip = settings.brownout_reset_fuse & ~vdd_ok;
    // no software path touches the watchdog: fuse and timeout only
    assign wd_reset = (state == CWD_ST_RUN) & wd_s & settings.watchdog_enable_fuse;
    assign wake = (wd_s & settings.watchdog_enable_fuse) | irq_s;
    assign xtal = is_crystal(settings.osc_mode);

    always_comb begin
        next_state = state;
        if (!ext_reset_s_n || brown_trip || wd_reset) begin
            next_state = CWD_ST_HOLD;
        end else begin
            unique case (state)
                CWD_ST_HOLD: begin
                    // delay follows its own bit only, whatever the brown-out fuse says
                    if (power_class && !settings.powerup_delay_enable_n) begin
                        next_state = CWD_ST_DELAY;
                    end else if (power_class && xtal) begin
                        next_state = CWD_ST_START;
                    end else begin
                        next_state = CWD_ST_RUN;
                    end
                end
                CWD_ST_DELAY: begin
                    if (cnt == PWRUP_LAST) begin
                        next_state = xtal ? CWD_ST_START : CWD_ST_RUN;
                    end
                end
                CWD_ST_START: begin
                    if (osc_rise && cnt == OST_LAST) begin
                        next_state = CWD_ST_RUN;
                    end
                end
                CWD_ST_RUN: begin
                    if (sleep_req) begin
                        next_state = CWD_ST_SLEEP;
                    end
                end
                CWD_ST_SLEEP: begin
                    if (wake) begin
                        next_state = xtal ? CWD_ST_START : CWD_ST_RUN;
                    end
                end
                default: begin
                    next_state = CWD_ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CWD_ST_HOLD;
            chip_reset_hold <= 1'b1;
            sleeping <= 1'b0;
        end else begin
            state <= next_state;
            chip_reset_hold <= (next_state == CWD_ST_HOLD) || (next_state == CWD_ST_DELAY) ||
                               (next_state == CWD_ST_START);
            sleeping <= (next_state == CWD_ST_SLEEP);
        end
    end

    // power-on and brown-out arm the delay; external and watchdog resets do not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_class <= 1'b1;
        end else if (brown_trip) begin
            power_class <= 1'b1;
        end else if (next_state == CWD_ST_RUN) begin
            power_class <= 1'b0;
        end
    end

    // one counter serves both timers; every state change restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else if (state == CWD_ST_DELAY || (state == CWD_ST_START && osc_rise)) begin
            cnt <= cnt + `CWD_CNT_W'(1);
        end
    end

    // settings follow the word only in the hold state, so programming a live part
    // changes nothing until the next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings <= decode(`CWD_ERASED);
        end else if (state == CWD_ST_HOLD) begin
            settings <= decode(cfg_word);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_drive_en <= 1'b0;
        end else begin
            xtal_drive_en <= xtal;
        end
    end

    // ---------------- APB slave ----------------
    logic [31:0] status_word;
    logic [31:0] rd_data;
    logic rd_err;

    always_comb begin
        status_word = '0;
        status_word[`CWD_STAT_STATE_LSB +: 3] = state;
        status_word[`CWD_STAT_PROTECT_BIT] = settings.code_protect_on;
        status_word[`CWD_STAT_BROWN_EN_BIT] = settings.brownout_reset_fuse;
        status_word[`CWD_STAT_BROWN_SEL_BIT] = settings.brownout_threshold_select;
        status_word[`CWD_STAT_PWRUP_N_BIT] = settings.powerup_delay_enable_n;
        status_word[`CWD_STAT_WATCHDOG_BIT] = settings.watchdog_enable_fuse;
        status_word[`CWD_STAT_OSC_LSB +: 2] = settings.osc_mode;
        status_word[`CWD_STAT_PROG_BIT] = prog_s;
        status_word[`CWD_STAT_POWER_BIT] = power_class;
        status_word[`CWD_STAT_HOLD_BIT] = chip_reset_hold;
    end

    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (in_cfg_space) begin
            if (!prog_s) begin
                rd_err = 1'b1;
            end else if (idx == `CWD_CFG_INDEX) begin
                rd_data = {16'h0000, cfg_view(cfg_word)};
            end else begin
                rd_data = {16'h0000, `CWD_ERASED};
            end
        end else if (idx == `CWD_STATUS_INDEX) begin
            rd_data = status_word;
            rd_err = pwrite;
        end else if (idx != `CWD_CONTROL_INDEX) begin
            rd_err = 1'b1;
        end
    end

    // answer prepared in setup, so every access phase completes in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup & rd_err;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end
endmodule

`default_nettype wire

// >>> include/cwd_map.svh
// address map, field positions, encodings and timing figures of the configuration word decoder
`ifndef CWD_MAP_SVH
`define CWD_MAP_SVH

// register word indices; byte address is four times the index
`define CWD_STATUS_INDEX 16'h0000
`define CWD_CONTROL_INDEX 16'h0001
`define CWD_CFG_INDEX 16'h2007
`define CWD_CFG_SPACE_LO 16'h2000
`define CWD_CFG_SPACE_HI 16'h3fff

// configuration word fields
`define CWD_PROTECT_BIT 13
`define CWD_BROWN_SEL_BIT 7
`define CWD_BROWN_EN_BIT 6
`define CWD_PWRUP_N_BIT 3
`define CWD_WATCHDOG_BIT 2
`define CWD_OSC_HI_BIT 1
`define CWD_OSC_LO_BIT 0
`define CWD_UNUSED_MASK 16'hdf30
`define CWD_ERASED 16'hffff

// oscillator mode encodings
`define CWD_OSC_LOWPWR_CODE 2'h0
`define CWD_OSC_CRYSTAL_CODE 2'h1
`define CWD_OSC_FAST_CODE 2'h2
`define CWD_OSC_RC_CODE 2'h3

// sequencer state codes, gray along hold, delay, start-up, run, sleep
`define CWD_ST_HOLD_CODE 3'h0
`define CWD_ST_DELAY_CODE 3'h1
`define CWD_ST_START_CODE 3'h3
`define CWD_ST_RUN_CODE 3'h2
`define CWD_ST_SLEEP_CODE 3'h6

// control register bits
`define CWD_CTRL_SLEEP_BIT 0
`define CWD_CTRL_ERASE_BIT 1

// status register fields
`define CWD_STAT_STATE_LSB 0
`define CWD_STAT_PROTECT_BIT 8
`define CWD_STAT_BROWN_EN_BIT 9
`define CWD_STAT_BROWN_SEL_BIT 10
`define CWD_STAT_PWRUP_N_BIT 11
`define CWD_STAT_WATCHDOG_BIT 12
`define CWD_STAT_OSC_LSB 13
`define CWD_STAT_PROG_BIT 15
`define CWD_STAT_POWER_BIT 16
`define CWD_STAT_HOLD_BIT 17

// timing: power-up delay in ms, clock rate in kHz, start-up count in oscillator cycles
`define CWD_PWRUP_MS 72
`define CWD_CLK_KHZ 100000
`define CWD_OST_CYCLES 1024
`define CWD_CNT_W 23
`define CWD_SYNC_W 7

`endif

// >>> include/cwd_pkg.sv
// types of the configuration word decoder
package cwd_pkg;
`include "cwd_map.svh"

    typedef enum logic [1:0] {
        CWD_OSC_LOWPWR = `CWD_OSC_LOWPWR_CODE,
        CWD_OSC_CRYSTAL = `CWD_OSC_CRYSTAL_CODE,
        CWD_OSC_FAST = `CWD_OSC_FAST_CODE,
        CWD_OSC_RC = `CWD_OSC_RC_CODE
    } cwd_osc_mode_t;

    typedef enum logic [2:0] {
        CWD_ST_HOLD = `CWD_ST_HOLD_CODE,
        CWD_ST_DELAY = `CWD_ST_DELAY_CODE,
        CWD_ST_START = `CWD_ST_START_CODE,
        CWD_ST_RUN = `CWD_ST_RUN_CODE,
        CWD_ST_SLEEP = `CWD_ST_SLEEP_CODE
    } cwd_state_t;

    typedef struct packed {
        logic code_protect_on;
        logic brownout_reset_fuse;
        logic brownout_threshold_select;
        logic powerup_delay_enable_n;
        logic watchdog_enable_fuse;
        cwd_osc_mode_t osc_mode;
    } cwd_settings_t;

endpackage

// >>> core/cwd_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module cwd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // sampling clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw pin levels
    output logic [WIDTH-1:0] sync_out // levels safe for logic
);
    logic [WIDTH-1:0] meta;

    // meta feeds only the second flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

`default_nettype wire

// >>> verif/cwd_prog_model.sv
// programmer-side model: programming-mode pin and external clock source
`timescale 1ns/1ps
`default_nettype none

module cwd_prog_model (
    input wire logic prog_req, // enter programming mode
    input wire logic osc_run, // run the external clock
    output logic prog_mode, // programming mode pin
    output var logic osc_out // external clock pin
);
    assign prog_mode = prog_req;
    initial osc_out = 1'b0;
    // clock parks low when idle so no stray edges reach the start-up count
    always #20 osc_out = osc_run ? ~osc_out : 1'b0;
endmodule

`default_nettype wire

// >>> verif/cwd_top_assertions.sv
// concurrent checks on the configuration word decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "cwd_map.svh"

module cwd_top_assertions
    import cwd_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // write
    input wire logic [17:0] paddr, // address
    input wire logic [31:0] pwdata, // wdata
    input wire logic [31:0] prdata, // rdata
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic ext_reset_n, // ext reset
    input wire logic vdd_above_hi, // supply hi
    input wire logic vdd_above_lo, // supply lo
    input wire logic watchdog_timeout, // wdt
    input wire logic irq_pending, // irq
    input wire logic prog_mode, // prog pin
    input wire cwd_settings_t settings, // settings
    input wire logic chip_reset_hold, // hold
    input wire logic sleeping, // sleep
    input wire logic xtal_drive_en, // xtal
    input wire logic program_memory_erase // erase
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] idx;
    logic acc;
    logic erase_wr;
    assign idx = paddr[17:2];
    assign acc = psel && penable && pready;
    assign erase_wr = acc && pwrite && idx == 16'h0001 && pwdata[1];

    property p_reset_val;
        $rose(presetn) |-> settings == 7'h3f && chip_reset_hold;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("settings not erased");
    property p_cfg_read;
        acc && !pwrite && !pslverr && idx == `CWD_CFG_INDEX |->
            (prdata[15:0] & `CWD_UNUSED_MASK) == `CWD_UNUSED_MASK && prdata[31:16] == 16'h0000;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("unused bits not one");
    property p_cfg_lock;
        (!prog_mode)[*4] ##0 (psel && !penable && idx >= 16'h2000 && idx <= 16'h3fff) |=> pready && pslverr;
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("config space open");
    property p_apb_wait;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("ready timing wrong");
    property p_erase;
        program_memory_erase |-> $past(erase_wr) ##1 !program_memory_erase;
    endproperty
    a_erase: assert property (p_erase) else $error("erase without request");
    property p_hold_set;
        !chip_reset_hold && !$past(chip_reset_hold) |-> $stable(settings);
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("settings moved");
    property p_xtal;
        !chip_reset_hold && !$past(chip_reset_hold) |-> xtal_drive_en == (settings.osc_mode != CWD_OSC_RC);
    endproperty
    a_xtal: assert property (p_xtal) else $error("xtal enable wrong");
    property p_sleep_stay;
        (sleeping && !irq_pending && !watchdog_timeout && ext_reset_n && vdd_above_hi && vdd_above_lo)[*4]
            |=> sleeping;
    endproperty
    a_sleep_stay: assert property (p_sleep_stay) else $error("woke without cause");
    property p_sleep_go;
        acc && pwrite && idx == 16'h0001 && pwdata[0] && !chip_reset_hold && !sleeping |-> ##[1:3] sleeping;
    endproperty
    a_sleep_go: assert property (p_sleep_go) else $error("sleep not entered");
endmodule

bind cwd_top cwd_top_assertions cwd_top_assertions_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_reset_n, .vdd_above_hi, .vdd_above_lo, .watchdog_timeout,
    .irq_pending, .prog_mode, .settings, .chip_reset_hold, .sleeping, .xtal_drive_en, .program_memory_erase);

`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
`include "cwd_map.svh"

module tb_top
    import cwd_pkg::*;
;
    localparam int PW = 20;
    localparam logic [17:0] A_ST = 18'h00000;
    localparam logic [17:0] A_CTL = 18'h00004;
    localparam logic [17:0] A_CFG = {`CWD_CFG_INDEX, 2'b00};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, hold, slp, xen, erase, prog, osc;
    logic ext_n = 1'b1, vhi = 1'b1, vlo = 1'b1, wdt = 1'b0, irq = 1'b0, preq = 1'b0, orun = 1'b0;
    logic [15:0] wl [5] = '{16'h0000, 16'hfffc, 16'hfffd, 16'hfffe, 16'hfff5};
    cwd_settings_t cfg_set;
    int fails = 0, total_checks = 0, ecnt = 0, n;

    always #5 pclk = ~pclk;
    always @(posedge pclk) if (erase === 1'b1) ecnt++;

    cwd_top #(.PWRUP_CYCLES(PW)) cwd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_reset_n(ext_n), .vdd_above_hi(vhi), .vdd_above_lo(vlo),
        .watchdog_timeout(wdt), .irq_pending(irq), .prog_mode(prog), .oscillator_input_pin(osc),
        .settings(cfg_set), .chip_reset_hold(hold), .sleeping(slp), .xtal_drive_en(xen),
        .program_memory_erase(erase));
    cwd_prog_model cwd_prog_model_inst (.prog_req(preq), .osc_run(orun), .prog_mode(prog), .osc_out(osc));

    function automatic logic [6:0] exp_set(input logic [15:0] w);
        return {~w[13], w[6], w[7], w[3], w[2], w[1:0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            end_sim();
        end
        @(posedge pclk);
    endtask
    // counts cycles until the chip leaves reset; bound covers the full start-up count
    task automatic wait_run(output int c);
        c = 0;
        while (hold !== 1'b0 && c < 6000) begin
            @(posedge pclk);
            c++;
        end
        if (hold !== 1'b0) begin
            fails++;
            end_sim();
        end
    endtask

    initial begin
        cyc(3);
        presetn <= 1'b1;
        cyc(8);
        chk("settings", 32'h3f, cfg_set);
        chk("hold", 32'h0, hold);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, A_CTL, 32'h1);
            cyc(4);
            chk("sleep", 32'h1, slp);
            case (k)
                0: irq <= 1'b1;
                1: wdt <= 1'b1;
                default: ext_n <= 1'b0;
            endcase
            cyc(1);
            irq <= 1'b0;
            wdt <= 1'b0;
            ext_n <= 1'b1;
            cyc(8);
            chk("wake", 32'h0, {slp, hold});
        end
        $display("test sleep done");
        apb(1'b0, A_CFG, 32'h0);
        chk("cfg_locked", 32'h1, rerr);
        apb(1'b1, A_ST, 32'h0);
        chk("status_wr", 32'h1, rerr);
        apb(1'b0, 18'h3fffc, 32'h0);
        chk("unmapped", 32'h1, rerr);
        preq <= 1'b1;
        cyc(4);
        apb(1'b0, A_CFG, 32'h0);
        chk("cfg_erased", 32'hffff, rdat);
        apb(1'b0, 18'h08000, 32'h0);
        chk("cfg_space", 32'hffff, rdat);
        $display("test access done");
        foreach (wl[i]) begin
            apb(1'b1, A_CTL, 32'h2);
            apb(1'b1, A_CFG, {16'h0, wl[i]});
            apb(1'b0, A_CFG, 32'h0);
            chk("cfg_read", {16'h0, wl[i] | 16'hdf30}, rdat);
            ext_n <= 1'b0;
            cyc(3);
            ext_n <= 1'b1;
            cyc(8);
            chk("settings", exp_set(wl[i]), cfg_set);
            chk("xtal", wl[i][1:0] != 2'h3, xen);
        end
        chk("erases", 32'h5, ecnt);
        $display("test decode done");
        vhi <= 1'b0;
        cyc(3);
        vhi <= 1'b1;
        cyc(15);
        vhi <= 1'b0;
        cyc(2);
        vhi <= 1'b1;
        cyc(12);
        apb(1'b0, A_ST, 32'h0);
        chk("state_delay", 32'h1, rdat[2:0]);
        cyc(15);
        apb(1'b0, A_ST, 32'h0);
        chk("state_start", 32'h3, rdat[2:0]);
        cyc(200);
        chk("hold_no_osc", 32'h1, hold);
        orun <= 1'b1;
        wait_run(n);
        orun <= 1'b0;
        chk("ost_len", 32'h1, n >= 4060 && n <= 4110);
        $display("test powerup done");
        ext_n <= 1'b0;
        cyc(3);
        ext_n <= 1'b1;
        cyc(1);
        chk("ext_hold", 32'h1, hold);
        wait_run(n);
        chk("ext_skip", 32'h1, n < 8);
        $display("test ext reset done");
        // one-cycle timeout in run: a single held cycle, then straight back to run
        wdt <= 1'b1;
        cyc(1);
        wdt <= 1'b0;
        cyc(3);
        chk("wdt_reset", 32'h1, hold);
        cyc(4);
        apb(1'b1, A_CTL, 32'h1);
        irq <= 1'b1;
        cyc(1);
        irq <= 1'b0;
        cyc(8);
        apb(1'b0, A_ST, 32'h0);
        chk("wake_start", 32'h3, rdat[2:0]);
        orun <= 1'b1;
        wait_run(n);
        orun <= 1'b0;
        chk("wake_ost", 32'h1, n >= 4060 && n <= 4110);
        $display("test watchdog done");
        cyc(5);
        end_sim();
    end
endmodule

`default_nettype wire
